//--- hw/lbc_pkg.sv
/*
 * Shared constants for the status LED blink controller: register map,
 * field positions, reset values, time base and the blink-rate table.
 * Assumes a 20 MHz system clock and a 32-bit APB register bus.
 */
package lbc_pkg;

	// ==================================================================
	// Time base
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_NS       = 1000000;                 // 1 ms blink step
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS; // Round down
	localparam int ACT_HOLD_MS   = 10;
	localparam int MS_W          = 14;

	// ==================================================================
	// Register indexes and byte addresses
	localparam logic [15:0] IDX_AUX  = 16'h40C1;
	localparam logic [15:0] IDX_RATE = 16'h40C2;
	localparam logic [15:0] IDX_LED1 = 16'h40C3;
	localparam logic [15:0] IDX_STAT = 16'h40C4;
	localparam logic [31:0] ADR_AUX  = {14'h0000, IDX_AUX, 2'b00};
	localparam logic [31:0] ADR_RATE = {14'h0000, IDX_RATE, 2'b00};
	localparam logic [31:0] ADR_LED1 = {14'h0000, IDX_LED1, 2'b00};
	localparam logic [31:0] ADR_STAT = {14'h0000, IDX_STAT, 2'b00};

	// ==================================================================
	// Reset values and masks
	localparam logic [15:0] RATE_RST   = 16'hEC75;
	localparam logic [15:0] LED1_RST   = 16'h0310;
	localparam logic [15:0] LED1_WMASK = 16'hFFFE;
	localparam logic [15:0] AUX_RST    = 16'h0000;

	// ==================================================================
	// Field positions
	localparam int AUX_INV   = 9;
	localparam int RATE_M0   = 12;
	localparam int RATE_M1   = 8;
	localparam int RATE_M2   = 4;
	localparam int RATE_M3   = 0;
	localparam int B_FORCE   = 15;
	localparam int B_FSEL    = 13;
	localparam int B_POLICY  = 12;
	localparam int B_FDX_ON  = 11;
	localparam int B_HDX_ON  = 10;
	localparam int B_TX_BLK  = 9;
	localparam int B_RX_BLK  = 8;
	localparam int B_TX_ON   = 7;
	localparam int B_RX_ON   = 6;
	localparam int B_FST_ON  = 5;
	localparam int B_SLW_ON  = 4;
	localparam int B_COL_BLK = 3;
	localparam int B_FST_BLK = 2;
	localparam int B_SLW_BLK = 1;

	// Force selector codes
	typedef enum logic [1:0] {
		LBC_F_OFF, LBC_F_ON, LBC_F_MODE1, LBC_F_MODE2
	} lbc_force_t;

	// Blink period in ms for a rate code
	function automatic logic [MS_W-1:0] lbc_period_ms(input logic [3:0] code);
		int p;
		case (code)
			4'h0: p = 10000;
			4'h1: p = 9400;
			4'h2: p = 8000;
			4'h3: p = 7400;
			4'h4: p = 6000;
			4'h5: p = 5000;
			4'h6: p = 4000;
			4'h7: p = 3000;
			4'h8, 4'h9: p = 1000;
			4'hA, 4'hB: p = 500;
			4'hC: p = 333;
			4'hD: p = 166;
			4'hE: p = 125;
			default: p = 100;
		endcase
		return p[MS_W-1:0];
	endfunction

	// OFF share in ms for a rate code, non-inverted
	function automatic logic [MS_W-1:0] lbc_off_ms(input logic [3:0] code);
		int pct;
		int off;
		case (code)
			4'h0, 4'h5: pct = 6;
			4'h1: pct = 7;
			4'h2, 4'h6: pct = 8;
			4'h3: pct = 9;
			4'h4, 4'h7: pct = 11;
			4'h8, 4'h9: pct = 16;
			default: pct = 50;
		endcase
		off = (int'(lbc_period_ms(code)) * pct) / 100;
		return off[MS_W-1:0];
	endfunction

endpackage

//--- hw/lbc_blink_gen.sv
/*
 * One blink-rate generator: turns a rate code into an ON/OFF phase.
 * Assumes a one-cycle 1 ms tick from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module lbc_blink_gen
	import lbc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// Control
	input  wire logic       tick_i,
	input  wire logic [3:0] code_i,
	input  wire logic       invert_i,
	// Phase
	output logic            phase_on_o
);

	typedef struct packed {
		logic [MS_W-1:0] cnt;
		logic [3:0]      code;
		logic            on;
	} lbc_gen_st_t;

	lbc_gen_st_t st;
	lbc_gen_st_t next_st;

	// ==================================================================
	// Period counter; a new code restarts the period cleanly
	always_comb begin
		next_st = st;
		if (code_i != st.code) begin
			next_st.code = code_i;
			next_st.cnt  = '0;
		end else if (tick_i) begin
			if (st.cnt >= lbc_period_ms(st.code) - 14'h0001)
				next_st.cnt = '0;
			else
				next_st.cnt = st.cnt + 14'h0001;
		end
		// OFF share first, then ON; inversion swaps the two
		next_st.on = (st.cnt >= lbc_off_ms(st.code)) ^ invert_i;
		if (!rst_b_i)
			next_st = '0;
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign phase_on_o = st.on;

	// Inside the OFF share the phase is off unless inverted
	chk_off_share: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(st.code == code_i && st.cnt < lbc_off_ms(st.code)) |=> (st.on == $past(invert_i)))
		else $error("blink phase wrong in OFF share");

endmodule

`default_nettype wire

//--- hw/lbc_led_ctrl.sv
/*
 * Status LED controller for the second LED: blink-rate table with
 * four blink modes, LED control word, APB register access.
 * Assumes PHY status inputs are synchronous to clk_i.
 */
// Summary of operation
// - Bits 15:12 pick blink mode 0 rate, reset 0xE.
// - Duty inversion bit swaps ON and OFF shares of every rate.
// - Codes 0-4 blink once per 10/9.4/8/7.4/6 s with given OFF share.
// - Codes 5-8 blink once per 5/4/3/1 s with given OFF share.
// - Codes 10,12-15 blink at 2/3/6/8/10 Hz, half OFF.
// - Bits 11:8 pick blink mode 1 rate, reset 0xC.
// - Bits 7:4 pick blink mode 2 rate, reset 0x7.
// - Bits 3:0 pick blink mode 3 rate, reset 0x5.
// - Force enable overrides all status-driven LED behaviour.
// - Force select: off, on, blink mode 1, blink mode 2.
// - Policy bit: blink on traffic always, else only if already on.
// - Full-duplex link lights LED when enabled and not blinking.
// - Half-duplex link lights LED when enabled and not blinking.
// - Transmit activity blinks at mode 2 when enabled and qualified.
// - Receive activity blinks at mode 2 when enabled and qualified.
// - Transmit activity lights LED at least 10 ms when enabled.
// - Receive activity lights LED at least 10 ms when enabled.
// - 100 Mb/s link lights LED when enabled and not blinking.
// - 10 Mb/s link lights LED when enabled and not blinking.
// - Collision on an up link blinks LED when enabled.
// - 100 Mb/s link blinks LED when enabled.
// - 10 Mb/s link blinks LED when enabled.
`timescale 1ns/1ps
`default_nettype none

module lbc_led_ctrl
	import lbc_pkg::*;
#(
	parameter int TICK_CNT = TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// PHY core status
	input  wire logic        link_up_i,
	input  wire logic        speed_100_i,
	input  wire logic        full_duplex_i,
	input  wire logic        tx_active_i,
	input  wire logic        rx_active_i,
	input  wire logic        collision_i,
	// LED drive, high means lit
	output logic             led_o
);

	localparam logic [MS_W-1:0] HOLD_LOAD = MS_W'(ACT_HOLD_MS + 1);

	typedef struct packed {
		logic [15:0]     aux;
		logic [15:0]     blink_rate_select;
		logic [15:0]     second_led_control;
		logic [31:0]     tick_cnt;
		logic            tick;
		logic [MS_W-1:0] hold_tx;
		logic [MS_W-1:0] hold_rx;
		logic            led;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
	} lbc_st_t;

	lbc_st_t st;
	lbc_st_t next_st;

	wire  [3:0] phase; // One bit per generator instance
	logic [3:0] rate_code [4];

	// ==================================================================
	// Blink mode generators
	assign rate_code[0] = st.blink_rate_select[RATE_M0 +: 4];
	assign rate_code[1] = st.blink_rate_select[RATE_M1 +: 4];
	assign rate_code[2] = st.blink_rate_select[RATE_M2 +: 4];
	assign rate_code[3] = st.blink_rate_select[RATE_M3 +: 4];

	// All four share one ms tick; codes map through the rate table
	for (genvar m = 0; m < 4; m++) begin : g_gen
		lbc_blink_gen u_gen (
			.clk_i      (clk_i),
			.rst_b_i    (rst_b_i),
			.tick_i     (st.tick),
			.code_i     (rate_code[m]),
			.invert_i   (st.aux[AUX_INV]),
			.phase_on_o (phase[m])
		);
	end

	// ==================================================================
	// LED decision terms
	logic [15:0] c;
	logic        link;
	logic        act_tx;
	logic        act_rx;
	logic        on_cond;
	logic        act_blink;
	logic        oth_blink;
	logic        led_val;

	always_comb begin
		c         = st.second_led_control;
		link      = link_up_i;
		act_tx    = link && tx_active_i;
		act_rx    = link && rx_active_i;
		// Steady-on candidates
		on_cond   = (c[B_FDX_ON] && link && full_duplex_i)
		         || (c[B_HDX_ON] && link && !full_duplex_i)
		         || (c[B_TX_ON] && st.hold_tx != '0)
		         || (c[B_RX_ON] && st.hold_rx != '0)
		         || (c[B_FST_ON] && link && speed_100_i)
		         || (c[B_SLW_ON] && link && !speed_100_i);
		// Traffic blink needs the policy bit or an active on condition
		act_blink = ((c[B_TX_BLK] && act_tx)
		          || (c[B_RX_BLK] && act_rx))
		          && (c[B_POLICY] || on_cond);
		oth_blink = (c[B_COL_BLK] && link && collision_i)
		         || (c[B_FST_BLK] && link && speed_100_i)
		         || (c[B_SLW_BLK] && link && !speed_100_i);
		// Resolve by priority
		if (c[B_FORCE]) begin
			case (lbc_force_t'(c[B_FSEL +: 2]))
				LBC_F_OFF:   led_val = 1'b0;
				LBC_F_ON:    led_val = 1'b1;
				LBC_F_MODE1: led_val = phase[1];
				LBC_F_MODE2: led_val = phase[2];
				default:     led_val = 1'b0;
			endcase
		end else if (act_blink) begin
			led_val = phase[2];
		end else if (oth_blink) begin
			led_val = phase[1];
		end else begin
			led_val = on_cond;
		end
	end

	// ==================================================================
	// APB decode
	logic        acc;
	logic        wr_done;
	logic        hit;
	logic [31:0] rd_val;

	always_comb begin
		acc     = psel_i && penable_i;
		wr_done = acc && st.pready && pwrite_i;
		hit     = 1'b1;
		rd_val  = 32'h0000_0000;
		case (paddr_i)
			ADR_AUX:  rd_val[15:0] = st.aux;
			ADR_RATE: rd_val[15:0] = st.blink_rate_select;
			ADR_LED1: rd_val[15:0] = st.second_led_control;
			ADR_STAT: rd_val[6:0]  = {st.hold_rx != '0, st.hold_tx != '0,
			                          phase, st.led};
			default:  hit = 1'b0;
		endcase
	end

	// ==================================================================
	// Next state
	always_comb begin
		next_st = st;

		// Free-running 1 ms tick
		next_st.tick = 1'b0;
		if (st.tick_cnt >= 32'(TICK_CNT - 1)) begin
			next_st.tick_cnt = 32'h0000_0000;
			next_st.tick     = 1'b1;
		end else begin
			next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
		end

		// Activity stretch; reload each active cycle keeps it lit
		if (act_tx)
			next_st.hold_tx = HOLD_LOAD;
		else if (st.tick && st.hold_tx != '0)
			next_st.hold_tx = st.hold_tx - 14'h0001;
		if (act_rx)
			next_st.hold_rx = HOLD_LOAD;
		else if (st.tick && st.hold_rx != '0)
			next_st.hold_rx = st.hold_rx - 14'h0001;

		next_st.led = led_val;

		// One wait state: pready rises in the second access cycle
		next_st.pready  = acc && !st.pready;
		next_st.pslverr = acc && !st.pready && !hit;
		next_st.prdata  = (acc && !st.pready && !pwrite_i) ? rd_val : 32'h0000_0000;

		// Writes land only at the completing edge
		if (wr_done) begin
			case (paddr_i)
				ADR_AUX:  next_st.aux = pwdata_i[15:0];
				ADR_RATE: next_st.blink_rate_select = pwdata_i[15:0];
				ADR_LED1: next_st.second_led_control = pwdata_i[15:0] & LED1_WMASK;
				default:  next_st.aux = st.aux;
			endcase
		end

		// Synchronous reset
		if (!rst_b_i) begin
			next_st                    = '0;
			next_st.aux                = AUX_RST;
			next_st.blink_rate_select  = RATE_RST;
			next_st.second_led_control = LED1_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	// ==================================================================
	// Outputs, all from flops
	assign prdata_o  = st.prdata;
	assign pready_o  = st.pready;
	assign pslverr_o = st.pslverr;
	assign led_o     = st.led;

	// ==================================================================
	// Checks
	chk_rst_mode0: assert property (@(posedge clk_i)
		!rst_b_i |=> st.blink_rate_select[RATE_M0 +: 4] == 4'hE)
		else $error("mode 0 rate reset wrong");
	chk_rst_mode1: assert property (@(posedge clk_i)
		!rst_b_i |=> st.blink_rate_select[RATE_M1 +: 4] == 4'hC)
		else $error("mode 1 rate reset wrong");
	chk_rst_mode2: assert property (@(posedge clk_i)
		!rst_b_i |=> st.blink_rate_select[RATE_M2 +: 4] == 4'h7)
		else $error("mode 2 rate reset wrong");
	chk_rst_mode3: assert property (@(posedge clk_i)
		!rst_b_i |=> st.blink_rate_select[RATE_M3 +: 4] == 4'h5)
		else $error("mode 3 rate reset wrong");
	chk_force_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(c[B_FORCE] && c[B_FSEL +: 2] == 2'b00) |=> !led_o)
		else $error("forced off LED is lit");
	chk_force_mode2: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(c[B_FORCE] && c[B_FSEL +: 2] == 2'b11) |=> led_o == $past(phase[2]))
		else $error("force mode 2 not following blink mode 2");
	chk_fdx_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!c[B_FORCE] && !act_blink && !oth_blink && c[B_FDX_ON]
		 && link_up_i && full_duplex_i) |=> led_o)
		else $error("full duplex LED not lit");
	chk_tx_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(act_tx && c[B_TX_ON]) |=> (st.hold_tx == HOLD_LOAD))
		else $error("transmit hold not loaded");
	chk_tx_blink: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!c[B_FORCE] && c[B_TX_BLK] && c[B_POLICY] && act_tx) |=> led_o == $past(phase[2]))
		else $error("transmit blink not at mode 2");
	chk_led_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!c[B_FORCE] && !act_blink && !oth_blink && !on_cond) |=> !led_o)
		else $error("LED lit without cause");
	chk_apb_wait: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(psel_i && penable_i && !pready_o) |=> pready_o ##1 !pready_o)
		else $error("pready not one cycle after wait");

	cov_force_blink: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		c[B_FORCE] && c[B_FSEL +: 2] == 2'b10 && led_o);
	cov_act_blink: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		act_blink && !c[B_FORCE]);
	cov_apb_error: cover property (@(posedge clk_i) disable iff (!rst_b_i)
		pready_o && pslverr_o);

endmodule

`default_nettype wire

//--- dv/tb_top.sv
/*
 * Self-checking bench for lbc_led_ctrl: APB register access, force
 * modes, blink rates, steady-on, blink and activity-hold conditions.
 * Assumes TICK_CNT is set to 20, so one blink step is 20 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module tb_top;
	import lbc_pkg::*;

	// ==================================================================
	// Signals
	localparam int TK    = 20;     // Cycles per blink step
	localparam int LIMIT = 100000; // Whole run fits well inside this
	logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i;
	logic [31:0] paddr_i, pwdata_i, prdata_o, rd;
	logic        pready_o, pslverr_o, err, led_o;
	logic        link_up_i, speed_100_i, full_duplex_i;
	logic        tx_active_i, rx_active_i, collision_i;
	int          n_fail, checked, cyc, cnt;
	int          cd[6]  = '{8, 15, 13, 12, 11, 14};
	int          per[6] = '{1000, 100, 166, 333, 500, 125};
	int          off[6] = '{160, 50, 83, 166, 250, 62};

	lbc_led_ctrl #(.TICK_CNT(TK)) u_lbc_led_ctrl (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.link_up_i(link_up_i), .speed_100_i(speed_100_i),
		.full_duplex_i(full_duplex_i), .tx_active_i(tx_active_i),
		.rx_active_i(rx_active_i), .collision_i(collision_i), .led_o(led_o)
	);

	// ==================================================================
	// Closing report
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==================================================================
	// Drivers
	// One APB transfer; pready and data are taken at the completing rising edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Only pready or the bench timeout ends this wait
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd  = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rchk(input logic [31:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK("prdata", e, rd)
	endtask

	// Status inputs: link, speed, duplex, tx, rx, collision
	task automatic setin(input logic [5:0] v);
		@(posedge clk_i);
		{link_up_i, speed_100_i, full_duplex_i, tx_active_i, rx_active_i, collision_i} <= v;
	endtask

	// Lit cycles over a whole period do not depend on blink phase
	task automatic blk(input logic [15:0] w, input logic [5:0] v, input int n, input int e);
		apb(1'b1, ADR_LED1, {16'h0000, w});
		setin(v);
		repeat (4) @(posedge clk_i);
		cnt = 0;
		repeat (n) begin
			@(negedge clk_i);
			if (led_o === 1'b1)
				cnt++;
		end
		`CHK("lit cycles", e, cnt)
	endtask

	// One-cycle activity pulse; hold lasts 10 to 11 steps
	task automatic act(input logic [15:0] w, input logic [5:0] v);
		// Let any hold left by earlier traffic drain first
		setin(6'h20);
		repeat (12 * TK) @(posedge clk_i);
		blk(w, 6'h20, 1, 0);
		setin(v);
		setin(6'h20);
		repeat (10 * TK - 5) @(negedge clk_i);
		`CHK("held", 1'b1, led_o)
		repeat (TK + 15) @(negedge clk_i);
		`CHK("released", 1'b0, led_o)
	endtask

	// ==================================================================
	// Clock and timeout
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc++;
		if (cyc >= LIMIT) begin
			n_fail++;
			test_done();
		end
	end

	// ==================================================================
	// Test sequence
	initial begin
		{rst_b_i, psel_i, penable_i, pwrite_i} = 4'h0;
		{paddr_i, pwdata_i} = 64'h0;
		{link_up_i, speed_100_i, full_duplex_i} = 3'h0;
		{tx_active_i, rx_active_i, collision_i} = 3'h0;
		{n_fail, checked, cyc} = 0;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		// Reset values, read-only bit, unmapped place
		rchk(ADR_RATE, 32'h0000_EC75);
		rchk(ADR_LED1, 32'h0000_0310);
		rchk(32'h0000_0000, 32'h0000_0000);
		`CHK("pslverr", 1'b1, err)
		apb(1'b1, ADR_LED1, 32'h0000_FFFF);
		rchk(ADR_LED1, 32'h0000_FFFE);
		// Force off overrides a lit steady condition, force on a dark one
		blk(16'h0310, 6'h20, 1, 1);
		blk(16'h8310, 6'h20, 1, 0);
		blk(16'hA000, 6'h00, 1, 1);
		// Rate table through force at blink mode 1
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, ADR_RATE, {16'h0000, 4'hE, cd[i][3:0], 8'hE5});
			blk(16'hC000, 6'h20, per[i] * TK, (per[i] - off[i]) * TK);
		end
		blk(16'hE000, 6'h20, 2500, 1260);
		apb(1'b1, ADR_AUX, 32'h0000_0200);
		blk(16'hE000, 6'h20, 2500, 1240);
		apb(1'b1, ADR_AUX, 32'h0000_0000);
		// Steady-on conditions
		blk(16'h0010, 6'h30, 1, 0);
		blk(16'h0020, 6'h30, 1, 1);
		blk(16'h0020, 6'h20, 1, 0);
		blk(16'h0800, 6'h28, 1, 1);
		blk(16'h0800, 6'h20, 1, 0);
		blk(16'h0400, 6'h20, 1, 1);
		blk(16'h0400, 6'h00, 1, 0);
		blk(16'h0000, 6'h3F, 1, 0);
		act(16'h0080, 6'h24);
		act(16'h0040, 6'h22);
		// Blink conditions: mode 1 at 100 ms, mode 2 at 125 ms
		apb(1'b1, ADR_RATE, 32'h0000_EFE5);
		blk(16'h0008, 6'h21, 2000, 1000);
		blk(16'h0008, 6'h01, 2000, 0);
		blk(16'h0004, 6'h30, 2000, 1000);
		blk(16'h0002, 6'h20, 2000, 1000);
		blk(16'h0018, 6'h21, 2000, 1000);
		blk(16'hA008, 6'h21, 2000, 2000);
		blk(16'h1200, 6'h24, 2500, 1260);
		blk(16'h1100, 6'h22, 2500, 1260);
		blk(16'h0210, 6'h24, 2500, 1260);
		blk(16'h0200, 6'h24, 2500, 0);
		test_done();
	end

endmodule
`default_nettype wire
